// file: hw/dac_cmd_decoder.sv
// command decoder and channel registers of an octal converter bus slave
// assumes scl/sda from pins, addr_sel from straps, apb from a 25 MHz master
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module dac_cmd_decoder
  import dac_cmd_pkg::*;
#(
  // arbitrary broadcast address, not tied to any part
  parameter logic [6:0] BCAST_ADDR = 7'h47
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] addr_sel_i,
  output logic update_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_d_q;
  logic sda_d_q;
  logic [2:0] addr_m_q;
  logic [2:0] addr_s_q;
  link_state_t st_q;
  byte_idx_t idx_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_lo_q;
  logic sda_oe_q;
  logic sda_o_q;
  logic rw_q;
  logic addr_hit_q;
  logic mack_q;
  logic rd_use_cmd_q;
  cmd_access_t cmd_q;
  logic [7:0] up_q;
  logic [7:0] lo_q;
  data_word_t inreg_q [NCHAN];
  data_word_t outreg_q [NCHAN];
  data_word_t power_q;
  data_word_t clear_q;
  data_word_t output_load_control_q;
  data_word_t last_q;
  logic upd_q;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;
  logic en_w;
  logic bcast_w;
  logic own_w;
  logic hit_w;
  logic apply_w;
  logic [3:0] cmd_w;
  logic [2:0] acc_ch;
  logic [NCHAN-1:0] sel_w;
  data_word_t data_w;
  data_word_t rd_word_w;
  data_word_t sel_in_w;
  logic access_w;
  logic wr_take_w;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // channel select decode
  function automatic logic [NCHAN-1:0] chan_mask(input logic [3:0] acc);
    logic [NCHAN-1:0] m;
    m = '0;
    if (acc == ACC_ALL) begin
      m = '1;
    end else if (!acc[3]) begin
      m[acc[2:0]] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [11:0] code12(input data_word_t w);
    return {w.upper, w.lower[7:4]};
  endfunction

  function automatic data_word_t reg_word(input cmd_access_t c);
    data_word_t w;
    w = '0;
    case (c.cmd)
      CMD_WR_IN: begin
        if (!c.acc[3]) w = inreg_q[c.acc[2:0]];
      end
      CMD_UPD: begin
        if (!c.acc[3]) w = outreg_q[c.acc[2:0]];
      end
      CMD_POWER: w = power_q;
      CMD_CLEAR: w = clear_q;
      CMD_LOAD: w = output_load_control_q;
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic logic chan_hit(input logic [7:0] a,
                                    input logic [7:0] base);
    return (a[7:5] == base[7:5]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic apb_hit(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_POWER) ||
           (a == OFF_CLEAR) || (a == OFF_LOAD) || (a == OFF_LAST) ||
           chan_hit(a, OFF_IN_BASE) || chan_hit(a, OFF_OUT_BASE);
  endfunction

  function automatic logic [31:0] apb_word(input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    if (a == OFF_CTRL) w = ctrl_q;
    else if (a == OFF_STATUS)
      w = {19'h0, rd_use_cmd_q, addr_hit_q, st_q, cmd_q};
    else if (a == OFF_POWER) w = {16'h0, power_q};
    else if (a == OFF_CLEAR) w = {16'h0, clear_q};
    else if (a == OFF_LOAD) w = {16'h0, output_load_control_q};
    else if (a == OFF_LAST) w = {16'h0, last_q};
    else if (chan_hit(a, OFF_IN_BASE)) w = {20'h0, code12(inreg_q[a[4:2]])};
    else if (chan_hit(a, OFF_OUT_BASE))
      w = {20'h0, code12(outreg_q[a[4:2]])};
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      addr_m_q <= 3'h0;
      addr_s_q <= 3'h0;
    end else if (ce_i) begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_d_q <= scl_sync_q[1];
      sda_d_q <= sda_sync_q[1];
      addr_m_q <= addr_sel_i;
      addr_s_q <= addr_m_q;
    end
  end

  assign scl_rise_w = scl_sync_q[1] & ~scl_d_q;
  assign scl_fall_w = ~scl_sync_q[1] & scl_d_q;
  assign start_w = scl_sync_q[1] & scl_d_q & ~sda_sync_q[1] & sda_d_q;
  assign stop_w = scl_sync_q[1] & scl_d_q & sda_sync_q[1] & ~sda_d_q;

  assign own_w = rx_sh_q[7:1] == {SLAVE_PREFIX, addr_s_q};
  assign bcast_w = rx_sh_q[7:1] == BCAST_ADDR;
  assign en_w = ctrl_q[CTRL_EN_BIT];
  assign hit_w = en_w && (own_w || (bcast_w && !rx_sh_q[0]));

  assign cmd_w = cmd_q.cmd;
  assign acc_ch = cmd_q.acc[2:0];
  assign sel_w = chan_mask(cmd_q.acc);
  assign data_w = {up_q, lo_q};
  assign sel_in_w = inreg_q[acc_ch];
  assign rd_word_w = rd_use_cmd_q ? reg_word(cmd_q) : last_q;
  // apply at lower byte ack fall
  assign apply_w = ce_i && st_q == ST_RX_ACK && scl_fall_w &&
                   idx_q == IDX_LO;

  // ----------------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= ST_IDLE;
      idx_q <= IDX_CMD;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      tx_lo_q <= 8'h00;
      sda_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      rw_q <= 1'b0;
      addr_hit_q <= 1'b0;
      mack_q <= 1'b0;
      rd_use_cmd_q <= 1'b0;
      cmd_q <= '0;
      up_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (ce_i) begin
      if (start_w) begin
        st_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_w) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        rd_use_cmd_q <= 1'b0;
      end else if (scl_rise_w) begin
        if (st_q == ST_ADDR || st_q == ST_RX || st_q == ST_TX) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (st_q == ST_ADDR || st_q == ST_RX) begin
          rx_sh_q <= {rx_sh_q[6:0], sda_sync_q[1]};
        end
        if (st_q == ST_TX_ACK) begin
          mack_q <= ~sda_sync_q[1];
        end
      end else if (scl_fall_w) begin
        case (st_q)
          ST_ADDR: begin
            if (bit_cnt_q == BIT_LAST) begin
              bit_cnt_q <= 4'h0;
              rw_q <= rx_sh_q[0];
              addr_hit_q <= hit_w;
              st_q <= hit_w ? ST_ADDR_ACK : ST_IDLE;
              sda_oe_q <= hit_w;
            end
          end
          ST_ADDR_ACK: begin
            if (rw_q) begin
              st_q <= ST_TX;
              idx_q <= IDX_UP;
              tx_sh_q <= rd_word_w.upper;
              tx_lo_q <= rd_word_w.lower;
              sda_oe_q <= ~rd_word_w.upper[7];
            end else begin
              st_q <= ST_RX;
              idx_q <= IDX_CMD;
              sda_oe_q <= 1'b0;
            end
          end
          ST_RX: begin
            if (bit_cnt_q == BIT_LAST) begin
              st_q <= ST_RX_ACK;
              sda_oe_q <= 1'b1;
              bit_cnt_q <= 4'h0;
              case (idx_q)
                IDX_CMD: cmd_q <= rx_sh_q;
                IDX_UP: up_q <= rx_sh_q;
                default: lo_q <= rx_sh_q;
              endcase
            end
          end
          ST_RX_ACK: begin
            st_q <= ST_RX;
            sda_oe_q <= 1'b0;
            case (idx_q)
              IDX_CMD: begin
                idx_q <= IDX_UP;
                rd_use_cmd_q <= 1'b1;
              end
              IDX_UP: idx_q <= IDX_LO;
              default: idx_q <= IDX_UP;
            endcase
          end
          ST_TX: begin
            if (bit_cnt_q == BIT_LAST) begin
              st_q <= ST_TX_ACK;
              sda_oe_q <= 1'b0;
              bit_cnt_q <= 4'h0;
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              sda_oe_q <= ~tx_sh_q[6];
            end
          end
          ST_TX_ACK: begin
            if (mack_q && idx_q == IDX_UP) begin
              st_q <= ST_TX;
              idx_q <= IDX_LO;
              tx_sh_q <= tx_lo_q;
              sda_oe_q <= ~tx_lo_q[7];
            end else begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // channel and control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        inreg_q[i] <= REG16_RST;
        outreg_q[i] <= REG16_RST;
      end
      power_q <= REG16_RST;
      clear_q <= REG16_RST;
      output_load_control_q <= REG16_RST;
      last_q <= REG16_RST;
      upd_q <= 1'b0;
    end else if (ce_i) begin
      upd_q <= apply_w && (cmd_w == CMD_UPD || cmd_w == CMD_WR_ALL ||
                           cmd_w == CMD_WR_UPD);
      if (apply_w) begin
        last_q <= data_w;
        case (cmd_w)
          CMD_WR_IN: begin
            for (int i = 0; i < NCHAN; i++) begin
              if (sel_w[i]) inreg_q[i] <= data_w;
            end
          end
          CMD_UPD: begin
            for (int i = 0; i < NCHAN; i++) begin
              if (sel_w[i]) outreg_q[i] <= inreg_q[i];
            end
          end
          CMD_WR_ALL: begin
            for (int i = 0; i < NCHAN; i++) begin
              if (sel_w[i]) inreg_q[i] <= data_w;
              outreg_q[i] <= sel_w[i] ? data_w : inreg_q[i];
            end
          end
          CMD_WR_UPD: begin
            for (int i = 0; i < NCHAN; i++) begin
              if (sel_w[i]) begin
                inreg_q[i] <= data_w;
                outreg_q[i] <= data_w;
              end
            end
          end
          CMD_POWER: power_q <= data_w;
          CMD_CLEAR: clear_q <= data_w;
          CMD_LOAD: output_load_control_q <= data_w;
          CMD_RESET: begin
            for (int i = 0; i < NCHAN; i++) begin
              inreg_q[i] <= REG16_RST;
              outreg_q[i] <= REG16_RST;
            end
            power_q <= REG16_RST;
            clear_q <= REG16_RST;
            output_load_control_q <= REG16_RST;
            last_q <= REG16_RST;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign access_w = psel_i & penable_i;
  assign wr_take_w = access_w & pready_q & pwrite_i & ~pslverr_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_q <= access_w & ~pready_q;
      if (access_w & ~pready_q) begin
        pslverr_q <= ~apb_hit(paddr_i);
        prdata_q <= pwrite_i ? 32'h0000_0000 : apb_word(paddr_i);
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_i && wr_take_w && paddr_i == OFF_CTRL) begin
      ctrl_q <= pwdata_i;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe_o = sda_oe_q;
  assign update_o = upd_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence addr_end_s;
    ce_i && st_q == ST_ADDR && scl_fall_w && bit_cnt_q == BIT_LAST;
  endsequence

  sequence lo_ack_s;
    ce_i && st_q == ST_RX_ACK && scl_fall_w && idx_q == IDX_LO;
  endsequence

  start_addr_a: assert property (
    ce_i && start_w |=> st_q == ST_ADDR && !sda_oe_o)
    else $error("start not followed by address phase");
  bcast_ack_a: assert property (
    addr_end_s ##0 (en_w && bcast_w && !rx_sh_q[0])
    |=> st_q == ST_ADDR_ACK && sda_oe_o)
    else $error("broadcast write not acknowledged");
  bcast_read_a: assert property (
    addr_end_s ##0 (bcast_w && rx_sh_q[0]) |=> st_q == ST_IDLE && !sda_oe_o)
    else $error("broadcast read acknowledged");
  own_addr_a: assert property (
    addr_end_s ##0 (!own_w && !bcast_w)
    |=> st_q == ST_IDLE && !sda_oe_o)
    else $error("foreign address acknowledged");
  wr_moment_a: assert property (
    lo_ack_s ##0 (cmd_w != CMD_RESET)
    |=> last_q == $past(data_w) && st_q == ST_RX && idx_q == IDX_UP)
    else $error("write not applied at lower byte ack");
  upd_one_a: assert property (
    lo_ack_s ##0 (cmd_w == CMD_UPD && !cmd_q.acc[3])
    |=> outreg_q[$past(acc_ch)] == $past(sel_in_w) ##1 !update_o)
    else $error("channel update wrong");
  wr_all_a: assert property (
    lo_ack_s ##0 (cmd_w == CMD_WR_ALL)
    |=> outreg_q[0] == inreg_q[0] && outreg_q[7] == inreg_q[7] && update_o)
    else $error("global load wrong");
  wr_upd_a: assert property (
    lo_ack_s ##0 (cmd_w == CMD_WR_UPD && !cmd_q.acc[3])
    |=> outreg_q[$past(acc_ch)] == $past(data_w) &&
        inreg_q[$past(acc_ch)] == $past(data_w))
    else $error("load and update wrong");
  bcast_wr_a: assert property (
    lo_ack_s ##0 (cmd_w == CMD_WR_IN && cmd_q.acc == ACC_ALL)
    |=> inreg_q[0] == $past(data_w) && inreg_q[7] == $past(data_w))
    else $error("all channel write wrong");
  sw_reset_a: assert property (
    lo_ack_s ##0 (cmd_w == CMD_RESET)
    |=> power_q == REG16_RST && last_q == REG16_RST &&
        inreg_q[5] == REG16_RST)
    else $error("software reset incomplete");
  tx_bit_a: assert property (
    st_q == ST_TX |-> sda_oe_o == !tx_sh_q[7])
    else $error("sent bit does not match shifter");

endmodule

// file: hw/dac_cmd_pkg.sv
// constants, types and register map of the octal channel command decoder
// assumes a single 25 MHz system clock; the two-wire bus is sampled by it
package dac_cmd_pkg;

  // ----------------------------------------------------------------------
  // command and access fields
  // ----------------------------------------------------------------------
  localparam int NCHAN = 8;
  localparam logic [3:0] SLAVE_PREFIX = 4'h9;
  localparam logic [3:0] CMD_WR_IN = 4'h0;
  localparam logic [3:0] CMD_UPD = 4'h1;
  localparam logic [3:0] CMD_WR_ALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER = 4'h4;
  localparam logic [3:0] CMD_CLEAR = 4'h5;
  localparam logic [3:0] CMD_LOAD = 4'h6;
  localparam logic [3:0] CMD_RESET = 4'h7;
  localparam logic [3:0] ACC_ALL = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_POWER = 8'h08;
  localparam logic [7:0] OFF_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_LOAD = 8'h10;
  localparam logic [7:0] OFF_LAST = 8'h14;
  localparam logic [7:0] OFF_IN_BASE = 8'h20;
  localparam logic [7:0] OFF_OUT_BASE = 8'h40;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [15:0] REG16_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] acc;
  } cmd_access_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } data_word_t;

  typedef enum logic [1:0] {IDX_CMD, IDX_UP, IDX_LO} byte_idx_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } link_state_t;

endpackage

// file: verification/link_master_model.sv
// two-wire bus master model for the command decoder's link
// assumes a 25 MHz clk_i and a pulled-up data wire resolved by the bench
`timescale 1ns/100ps
module link_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one bit, data set in scl low, sampled at end of scl high
  task automatic bit_x(input logic b, output logic s);
    hc(1);
    sda_oe_o <= ~b;
    hc(3);
    scl_o <= 1'b1;
    hc(4);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    hc(1);
    sda_oe_o <= 1'b0;
    hc(6);
    scl_o <= 1'b1;
    hc(4);
    sda_oe_o <= 1'b1;
    hc(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    hc(1);
    sda_oe_o <= 1'b1;
    hc(3);
    scl_o <= 1'b1;
    hc(4);
    sda_oe_o <= 1'b0;
    hc(4);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  // byte in, then master ack or nack
  task automatic rb(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(nack, s);
  endtask
endmodule

// file: verification/dac_cmd_decoder_tb.sv
// self-checking bench for the octal channel command decoder
// assumes the link master model and a pulled-up data wire
`timescale 1ns/100ps
module dac_cmd_decoder_tb;
  import dac_cmd_pkg::*;
  // arbitrary broadcast address
  localparam logic [6:0] BCAST = 7'h47;
  logic clk_i, resetn_i, ce_i, scl_i, m_oe, sda_oe_o, sda_o, update_o;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [2:0] addr_sel_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [11:0] in_m [8];
  logic [11:0] out_m [8];
  logic [15:0] pwr_m, clr_m, ld_m, last_m;
  logic [6:0] own;
  int miscompares, total_checks, upd_n;
  wire sda_i = ~(m_oe | sda_oe_o);

  dac_cmd_decoder #(.BCAST_ADDR(BCAST)) uut (.clk_i, .resetn_i, .ce_i,
    .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i, .update_o, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o);
  link_master_model m (.clk_i, .sda_i, .scl_o(scl_i), .sda_oe_o(m_oe));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (update_o === 1'b1) upd_n++;
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end

  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic model(logic [7:0] c, logic [15:0] w);
    for (int i = 0; i < NCHAN; i++)
      if (c[3:0] == i || c[3:0] == ACC_ALL) begin
        if (c[7:4] inside {0, 2, 3}) in_m[i] = w[15:4];
        if (c[7:4] inside {1, 3}) out_m[i] = in_m[i];
      end
    if (c[7:4] == CMD_WR_ALL) out_m = in_m;
    if (c[7:4] == CMD_POWER) pwr_m = w;
    if (c[7:4] == CMD_CLEAR) clr_m = w;
    if (c[7:4] == CMD_LOAD) ld_m = w;
    last_m = w;
    if (c[7:4] == CMD_RESET) begin
      in_m = '{default: 12'h0};
      out_m = in_m;
      {pwr_m, clr_m, ld_m, last_m} = 64'h0;
    end
  endtask
  task automatic check_all();
    logic [31:0] r;
    for (int i = 0; i < NCHAN; i++) begin
      rreg(OFF_IN_BASE + 8'(4 * i), r);
      cmp_word("input code", {20'h0, in_m[i]}, r);
      rreg(OFF_OUT_BASE + 8'(4 * i), r);
      cmp_word("output code", {20'h0, out_m[i]}, r);
    end
    rreg(OFF_POWER, r);
    cmp_word("power reg", {16'h0, pwr_m}, r);
    rreg(OFF_CLEAR, r);
    cmp_word("clear reg", {16'h0, clr_m}, r);
    rreg(OFF_LOAD, r);
    cmp_word("load reg", {16'h0, ld_m}, r);
    rreg(OFF_LAST, r);
    cmp_word("last word", {16'h0, last_m}, r);
  endtask
  task automatic open(logic [6:0] a, logic rw, logic exp);
    logic k;
    m.start();
    m.wb({a, rw}, k);
    cmp_bit("address ack", exp, k);
  endtask
  task automatic pair(logic [7:0] c);
    logic [15:0] w;
    logic a1, a2;
    int u;
    w = 16'($urandom);
    m.wb(w[15:8], a1);
    u = upd_n;
    m.wb(w[7:0], a2);
    cmp_bit("data ack", 1'b1, a1 & a2);
    cmp_word("early update", u, upd_n);
    repeat (8) @(posedge clk_i);
    model(c, w);
    cmp_word("updates", u + int'(c[7:4] inside {1, 2, 3}), upd_n);
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] c, int np);
    logic k;
    open(a, 1'b0, 1'b1);
    m.wb(c, k);
    cmp_bit("command ack", 1'b1, k);
    repeat (np) pair(c);
    m.stop();
  endtask
  task automatic rdl(logic use_c, logic [7:0] c, output logic [15:0] v);
    logic k;
    if (use_c) begin
      open(own, 1'b0, 1'b1);
      m.wb(c, k);
      cmp_bit("read command ack", 1'b1, k);
    end
    open(own, 1'b1, 1'b1);
    m.rb(1'b0, v[15:8]);
    cmp_bit("data out level", 1'b0, sda_o);
    m.rb(1'b1, v[7:0]);
    m.stop();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] v;
    logic e;
    int ch;
    {resetn_i, psel_i, penable_i, pwrite_i} = 4'h0;
    {ce_i, paddr_i, pwdata_i} = {1'b1, 40'h0};
    void'($urandom(32'hA68ED544));
    addr_sel_i = 3'($urandom);
    own = {SLAVE_PREFIX, addr_sel_i};
    in_m = '{default: 12'h0};
    out_m = in_m;
    {pwr_m, clr_m, ld_m, last_m} = 64'h0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rreg(OFF_CTRL, r);
    cmp_word("ctrl reset", CTRL_RST, r);
    apb(1'b0, 8'h18, 32'h0, r, e);
    cmp_bit("unmapped error", 1'b1, e);
    check_all();
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      ch = (k % 5 == 4) ? 15 : int'($urandom_range(7));
      wr(own, {4'(k % 4), 4'(ch)}, 1);
    end
    wr(own, {CMD_WR_UPD, 4'h1}, 3);
    wr(BCAST, {CMD_WR_IN, ACC_ALL}, 1);
    check_all();
    $display("test channel writes done");
    for (int k = 4; k < 7; k++) begin
      wr(own, {4'(k), 4'(k)}, 1);
      rdl(1'b1, {4'(k), 4'hA}, v);
      r = {16'h0, k == 4 ? pwr_m : k == 5 ? clr_m : ld_m};
      cmp_word("reg readback", r, {16'h0, v});
    end
    for (int k = 0; k < 2; k++) begin
      ch = int'($urandom_range(7));
      rdl(1'b1, {4'(k), 4'(ch)}, v);
      r = {20'h0, k == 0 ? in_m[ch] : out_m[ch]};
      cmp_word("channel readback", r, {20'h0, v[15:4]});
    end
    rdl(1'b0, 8'h0, v);
    cmp_word("last readback", {16'h0, last_m}, {16'h0, v});
    $display("test readback done");
    open(BCAST, 1'b1, 1'b0);
    m.stop();
    open({SLAVE_PREFIX, addr_sel_i ^ 3'h1}, 1'b0, 1'b0);
    m.stop();
    ce_i <= 1'b0;
    open(own, 1'b0, 1'b0);
    m.stop();
    ce_i <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0, r, e);
    open(own, 1'b0, 1'b0);
    m.stop();
    apb(1'b1, OFF_CTRL, CTRL_RST, r, e);
    wr(own, {CMD_RESET, 4'h0}, 1);
    check_all();
    $display("test refusals and reset done");
    report_and_stop();
  end
endmodule
